// >>> hw/ptm_timer.v
// Added by the designer: register access over AXI4-Lite and the register offsets.
`include "ptm_defs.vh"

module ptm_timer #(
   parameter ADDR_W = 8
) (
   input  wire              aclk,
   input  wire              aresetn,
   input  wire [ADDR_W-1:0] s_axi_awaddr,
   input  wire              s_axi_awvalid,
   output wire              s_axi_awready,
   input  wire [31:0]       s_axi_wdata,
   input  wire [3:0]        s_axi_wstrb,
   input  wire              s_axi_wvalid,
   output wire              s_axi_wready,
   output wire [1:0]        s_axi_bresp,
   output wire              s_axi_bvalid,
   input  wire              s_axi_bready,
   input  wire [ADDR_W-1:0] s_axi_araddr,
   input  wire              s_axi_arvalid,
   output wire              s_axi_arready,
   output wire [31:0]       s_axi_rdata,
   output wire [1:0]        s_axi_rresp,
   output wire              s_axi_rvalid,
   input  wire              s_axi_rready,
   input  wire              ext_count_input,
   input  wire              sev_reset_in,
   output wire              irq
);

   // ==========================================================
   // state
   reg [5:0]        ctrl_ff;
   reg [15:0]       count_ff;
   reg [7:0]        hi_buf_ff;
   reg [15:0]       period_ff;
   reg              flag_ff;
   reg              int_en_ff;
   reg [1:0]        ph_ff;
   reg [2:0]        samp_ff;
   reg              pend_ff;
   reg              ext_prev_ff;
   reg [2:0]        pre_ff;
   reg              aw_got_ff;
   reg              w_got_ff;
   reg [ADDR_W-1:0] awaddr_ff;
   reg [31:0]       wdata_ff;
   reg [3:0]        wstrb_ff;
   reg              bvalid_ff;
   reg [1:0]        bresp_ff;
   reg              rvalid_ff;
   reg [31:0]       rdata_ff;
   reg [1:0]        rresp_ff;

   // ==========================================================
   // prescale mask: terminal count of the divider
   // all mask bits set ends a division; mask zero ticks every event
   function [2:0] ps_mask;
      input [1:0] sel;
      begin
         case (sel)
            2'h0:    ps_mask = 3'h0;
            2'h1:    ps_mask = 3'h1;
            2'h2:    ps_mask = 3'h3;
            default: ps_mask = 3'h7;
         endcase
      end
   endfunction

   // address decode, used by read and write paths
   // full-width compare, so unaligned offsets get the error answer
   function is_reg;
      input [ADDR_W-1:0] a;
      input [7:0]        off;
      begin
         is_reg = (a == off[ADDR_W-1:0]);
      end
   endfunction

   // ==========================================================
   // control field views
   // bits above the one-shot bit are not stored and read as zero
   wire       run      = ctrl_ff[`PTM_B_RUN];
   wire       src_ext  = ctrl_ff[`PTM_B_SRC];
   wire       bypass   = ctrl_ff[`PTM_B_BYPASS];
   wire [1:0] ps_sel   = ctrl_ff[`PTM_B_PS_HI:`PTM_B_PS_LO];
   wire       one_shot = ctrl_ff[`PTM_B_ONESHOT];

   // ==========================================================
   // write channel: address and data taken in either order
   wire do_wr  = aw_got_ff && w_got_ff && !bvalid_ff;
   wire wr_ctl = do_wr && is_reg(awaddr_ff, `PTM_OFF_CTRL);
   wire wr_lo  = do_wr && is_reg(awaddr_ff, `PTM_OFF_CNT_LO);
   wire wr_hi  = do_wr && is_reg(awaddr_ff, `PTM_OFF_HI_BUF);
   wire wr_per = do_wr && is_reg(awaddr_ff, `PTM_OFF_PERIOD);
   wire wr_clr = do_wr && is_reg(awaddr_ff, `PTM_OFF_INT_CLR);
   wire wr_en  = do_wr && is_reg(awaddr_ff, `PTM_OFF_INT_EN);
   wire wr_ok  = wr_ctl | wr_lo | wr_hi | wr_per | wr_clr | wr_en
               | is_reg(awaddr_ff, `PTM_OFF_STATUS);
   wire b0     = wstrb_ff[0];

   assign s_axi_awready = !aw_got_ff && !bvalid_ff;
   assign s_axi_wready  = !w_got_ff && !bvalid_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;

   // hold each half until both are present, then answer
   // the answer leaves two edges after the second half arrives
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got_ff <= 1'b0;
         w_got_ff  <= 1'b0;
         awaddr_ff <= {ADDR_W{1'b0}};
         wdata_ff  <= 32'h0000_0000;
         wstrb_ff  <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff  <= `PTM_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_got_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_got_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (do_wr)
         begin
            aw_got_ff <= 1'b0;
            w_got_ff  <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_ok ? `PTM_RESP_OKAY : `PTM_RESP_SLVERR;
         end
         else if (bvalid_ff && s_axi_bready)
            bvalid_ff <= 1'b0;
      end
   end

   // ==========================================================
   // read channel: one read in flight, registered data
   wire rd_take = s_axi_arvalid && s_axi_arready;
   wire rd_lo   = rd_take && is_reg(s_axi_araddr, `PTM_OFF_CNT_LO);

   assign s_axi_arready = !rvalid_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;

   reg [31:0] nxt_rdata;
   reg [1:0]  nxt_rresp;

   // read mux, unmapped and write-only answer zero
   // status is read-only: a write to it is accepted and dropped
   always @*
   begin
      nxt_rdata = 32'h0000_0000;
      nxt_rresp = `PTM_RESP_OKAY;
      if (is_reg(s_axi_araddr, `PTM_OFF_CTRL))
         nxt_rdata = {26'h000_0000, ctrl_ff};
      else if (is_reg(s_axi_araddr, `PTM_OFF_CNT_LO))
         nxt_rdata = {24'h00_0000, count_ff[7:0]};
      else if (is_reg(s_axi_araddr, `PTM_OFF_HI_BUF))
         nxt_rdata = {24'h00_0000, hi_buf_ff};
      else if (is_reg(s_axi_araddr, `PTM_OFF_PERIOD))
         nxt_rdata = {16'h0000, period_ff};
      else if (is_reg(s_axi_araddr, `PTM_OFF_STATUS))
         nxt_rdata = {31'h0000_0000, flag_ff};
      else if (is_reg(s_axi_araddr, `PTM_OFF_INT_EN))
         nxt_rdata = {31'h0000_0000, int_en_ff};
      else if (!is_reg(s_axi_araddr, `PTM_OFF_INT_CLR))
         nxt_rresp = `PTM_RESP_SLVERR;
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h0000_0000;
         rresp_ff  <= `PTM_RESP_OKAY;
      end
      else if (rd_take)
      begin
         rvalid_ff <= 1'b1;
         rdata_ff  <= nxt_rdata;
         rresp_ff  <= nxt_rresp;
      end
      else if (s_axi_rready)
         rvalid_ff <= 1'b0;
   end

   // ==========================================================
   // instruction phase and input edge detection
   wire [2:0] samp_new = {samp_ff[1:0], ext_count_input};
   wire       samp_now = (ph_ff == `PTM_PH_TWO) || (ph_ff == `PTM_PH_FOUR);
   wire       ph_one   = (ph_ff == `PTM_PH_ONE);

   // free phase counter, sample shift and pending increment
   // runs while stopped, so a start lands anywhere in the cycle
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ph_ff       <= `PTM_PH_ONE;
         samp_ff     <= 3'h0;
         pend_ff     <= 1'b0;
         ext_prev_ff <= 1'b0;
      end
      else
      begin
         ph_ff       <= ph_ff + 2'h1;
         ext_prev_ff <= ext_count_input;
         if (samp_now)
         begin
            samp_ff <= samp_new;
            // low then two highs marks one rising edge
            if (samp_new == `PTM_SYNC_EDGE)
               pend_ff <= 1'b1;
         end
         else if (ph_one)
            pend_ff <= 1'b0;
      end
   end

   // raw count event before the prescaler
   // bypass is an edge detect on aclk: pulses need one clock each way
   reg raw_evt;
   always @*
   begin
      if (!src_ext)
         raw_evt = ph_one;
      else if (bypass)
         raw_evt = ext_count_input && !ext_prev_ff;
      else
         raw_evt = ph_one && pend_ff;
   end

   // ==========================================================
   // prescaler
   wire [2:0] mask    = ps_mask(ps_sel);
   wire       tick    = run && raw_evt && ((pre_ff & mask) == mask);
   // trigger alone may start a stopped single-shot counter
   wire       sev_go  = sev_reset_in && one_shot && !run;
   wire       at_per  = (count_ff == period_ff);
   wire       at_max  = (count_ff == `PTM_CNT_MAX);
   wire       hit     = tick && (at_per || (!one_shot && at_max));

   // cleared while stopped, so a restart divides from zero
   always @(posedge aclk)
   begin
      if (!aresetn)
         pre_ff <= 3'h0;
      else if (wr_lo && b0)
         pre_ff <= 3'h0;
      else if (!run)
         pre_ff <= 3'h0;
      else if (raw_evt)
         pre_ff <= tick ? 3'h0 : pre_ff + 3'h1;
   end

   // ==========================================================
   // period pair, one byte lane per write strobe
   // no run interlock: a period written below the live count
   // is passed, and the count runs round before it matches
   wire [15:0] nxt_period;
   genvar      gi;

   generate
      for (gi = 0; gi < 2; gi = gi + 1)
      begin : g_per_lane
         // a lane moves only under its own strobe
         assign nxt_period[gi*8 +: 8] = (wr_per && wstrb_ff[gi])
                                      ? wdata_ff[gi*8 +: 8]
                                      : period_ff[gi*8 +: 8];
      end
   endgenerate

   // ==========================================================
   // count, buffer, period and control
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_ff   <= `PTM_RST_CTRL;
         count_ff  <= `PTM_RST_COUNT;
         hi_buf_ff <= `PTM_RST_BYTE;
         period_ff <= `PTM_RST_PERIOD;
      end
      else
      begin
         // control write touches no count state
         // a software write beats the hardware run clear or set
         if (wr_ctl && b0)
            ctrl_ff <= wdata_ff[5:0];
         else if (hit && one_shot)
            ctrl_ff[`PTM_B_RUN] <= 1'b0;
         else if (sev_go)
            ctrl_ff[`PTM_B_RUN] <= 1'b1;

         // low byte read snapshots the live high byte
         if (rd_lo)
            hi_buf_ff <= count_ff[15:8];
         else if (wr_hi && b0)
            hi_buf_ff <= wdata_ff[7:0];

         period_ff <= nxt_period;

         // software load beats trigger beats counting
         // a trigger clears the count in either mode, even stopped
         if (wr_lo && b0)
            count_ff <= {hi_buf_ff, wdata_ff[7:0]};
         else if (sev_reset_in)
            count_ff <= `PTM_RST_COUNT;
         else if (hit)
            count_ff <= `PTM_RST_COUNT;
         else if (tick)
            count_ff <= count_ff + 16'h0001;
      end
   end

   // ==========================================================
   // event flag and interrupt
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         flag_ff   <= 1'b0;
         int_en_ff <= 1'b0;
      end
      else
      begin
         // a new hit wins over a clear in the same cycle
         // so an event under the clear is never lost
         if (hit)
            flag_ff <= 1'b1;
         else if (wr_clr && b0 && wdata_ff[0])
            flag_ff <= 1'b0;
         if (wr_en && b0)
            int_en_ff <= wdata_ff[0];
      end
   end

   // level output, high while an enabled flag is set
   assign irq = flag_ff && int_en_ff;

endmodule // ptm_timer

// >>> hw/ptm_defs.vh
`ifndef PTM_DEFS_VH
`define PTM_DEFS_VH
// ==========================================================
// register byte offsets
`define PTM_OFF_CTRL     8'h00
`define PTM_OFF_CNT_LO   8'h04
`define PTM_OFF_HI_BUF   8'h08
`define PTM_OFF_PERIOD   8'h0C
`define PTM_OFF_STATUS   8'h10
`define PTM_OFF_INT_CLR  8'h14
`define PTM_OFF_INT_EN   8'h18
// ==========================================================
// counter_control field positions
`define PTM_B_RUN        0
`define PTM_B_SRC        1
`define PTM_B_BYPASS     2
`define PTM_B_PS_LO      3
`define PTM_B_PS_HI      4
`define PTM_B_ONESHOT    5
// ==========================================================
// reset values and encodings
`define PTM_RST_CTRL     6'h00
`define PTM_RST_COUNT    16'h0000
`define PTM_RST_PERIOD   16'hFFFF
`define PTM_RST_BYTE     8'h00
`define PTM_CNT_MAX      16'hFFFF
`define PTM_RESP_OKAY    2'h0
`define PTM_RESP_SLVERR  2'h2
// ==========================================================
// instruction phases, core clocks per instruction cycle
`define PTM_PH_ONE       2'h0
`define PTM_PH_TWO       2'h1
`define PTM_PH_FOUR      2'h3
`define PTM_SYNC_EDGE    3'h3
`endif

// >>> test/ptm_timer_sva.sv
// ==========================================================
// port-level checks on the timer's bus and interrupt
module ptm_timer_sva #(
   parameter ADDR_W = 8
) (
   input wire logic              aclk,
   input wire logic              aresetn,
   input wire logic              s_axi_awvalid,
   input wire logic              s_axi_awready,
   input wire logic              s_axi_wvalid,
   input wire logic              s_axi_wready,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic [31:0]       s_axi_rdata,
   input wire logic [1:0]        s_axi_rresp,
   input wire logic              s_axi_rvalid,
   input wire logic              s_axi_rready,
   input wire logic              irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // ==========================================================
   // assertions
   a_rst_idle: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq)
      else $error("outputs busy after reset");
   a_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_rd_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   a_wr_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken during response");
   a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken during response");
   a_slverr_hole: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h18
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   a_irq_falls: assert property ($fell(irq) |-> $rose(s_axi_bvalid))
      else $error("irq dropped without software write");

   // main scenarios reached
   c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
   c_irq: cover property ($rose(irq));
   c_wr_done: cover property (s_axi_bvalid && s_axi_bready);
endmodule // ptm_timer_sva

bind ptm_timer ptm_timer_sva #(.ADDR_W(ADDR_W)) ptm_timer_sva_i (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .irq(irq));

// >>> test/ptm_pulse_src.sv
// ==========================================================
// external count source, idle low between pulses
module ptm_pulse_src (
   input  wire logic aclk,
   output logic      ext_count_input
);
   timeunit 1ns;
   timeprecision 1ns;
   initial ext_count_input = 1'h0;
   // eight clocks each way, well over half an instruction cycle
   task automatic send(input int n);
      repeat (n)
      begin
         repeat (8) @(posedge aclk);
         ext_count_input <= 1'h1;
         repeat (8) @(posedge aclk);
         ext_count_input <= 1'h0;
      end
      repeat (8) @(posedge aclk);
   endtask
endmodule // ptm_pulse_src

// >>> test/ptm_timer_tb_top.sv
// ==========================================================
// register-level bench for the period timer
module ptm_timer_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        aclk = 1'h0, aresetn = 1'h0, sev = 1'h0;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rd_v;
   logic [1:0]  rs, bs;
   wire         awready, wready, bvalid, arready, rvalid, irq, ext;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   int          n_fail = 0, check_count = 0;
   logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
   logic [31:0] rv [8] = '{32'h0, 32'h0, 32'h0, 32'hFFFF, 32'h0, 32'h0, 32'h0, 32'h0};

   always #25 aclk = ~aclk;

   ptm_timer #(.ADDR_W(8)) ptm_timer_i (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .ext_count_input(ext), .sev_reset_in(sev), .irq(irq));
   ptm_pulse_src ptm_pulse_src_i (.aclk(aclk), .ext_count_input(ext));

   // ==========================================================
   // compare, verdict
   task automatic chk(input logic [31:0] seen, exp, input string what);
      check_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic hung(input int k);
      if (k >= 50)
      begin
         n_fail++;
         $display("[FAIL] bus response expected in 50 cycles seen none");
         results();
      end
   endtask

   // ==========================================================
   // bus cycles; one idle edge after each so no strobe is set twice at once
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do
      begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
         k++;
      end while (!bvalid && k < 50);
      bs = bresp;
      bready <= 1'h0;
      hung(k);
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int k;
      k = 0;
      araddr <= a;
      arvalid <= 1'h1;
      do
      begin
         @(posedge aclk);
         if (arready) arvalid <= 1'h0;
         k++;
      end while (!rvalid && k < 50);
      // answer left waiting one cycle so its hold is exercised
      rready <= 1'h1;
      @(posedge aclk);
      d = rdata;
      r = rresp;
      rready <= 1'h0;
      hung(k);
      @(posedge aclk);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string what);
      rd(a, rd_v, rs);
      chk(rd_v, exp, what);
   endtask

   // ==========================================================
   // main sequence
   initial
   begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      for (int i = 0; i < 8; i++)
      begin
         rd(ra[i], rd_v, rs);
         chk(rd_v, rv[i], "reset value");
         chk({30'h0, rs}, (i == 7) ? 32'h2 : 32'h0, "response code");
      end
      wr(8'h1C, 32'h1);
      chk({30'h0, bs}, 32'h2, "write response unmapped");
      $display("test reset_values done");
      // high byte reaches the count only with the low write
      wr(8'h08, 32'h12);
      chk({30'h0, bs}, 32'h0, "write response okay");
      wr(8'h04, 32'h34);
      rc(8'h04, 32'h34, "count low");
      rc(8'h08, 32'h12, "high buffer");
      wr(8'h08, 32'h56);
      rc(8'h04, 32'h34, "count low again");
      rc(8'h08, 32'h12, "high snapshot");
      $display("test byte_buffer done");
      // period 3 gives four ticks of four clocks; trigger starts it
      wr(8'h0C, 32'h3);
      wr(8'h00, 32'h20);
      rc(8'h04, 32'h34, "count kept by control write");
      sev <= 1'h1;
      @(posedge aclk);
      sev <= 1'h0;
      rc(8'h00, 32'h21, "run by trigger");
      repeat (40) @(posedge aclk);
      rc(8'h00, 32'h20, "run cleared");
      rc(8'h10, 32'h1, "event flag");
      rc(8'h04, 32'h0, "count cleared");
      wr(8'h14, 32'h1);
      wr(8'h00, 32'h1);
      repeat (40) @(posedge aclk);
      rc(8'h00, 32'h1, "still running");
      rc(8'h10, 32'h1, "event flag again");
      wr(8'h18, 32'h1);
      chk({31'h0, irq}, 32'h1, "irq raised");
      // stop first so no new match can land under the clear
      wr(8'h00, 32'h0);
      wr(8'h14, 32'h1);
      chk({31'h0, irq}, 32'h0, "irq cleared");
      $display("test single_continuous done");
      // external pulses: divide by four, then unsynchronised
      wr(8'h0C, 32'hFFFF);
      wr(8'h00, 32'h12);
      wr(8'h08, 32'h0);
      wr(8'h04, 32'h0);
      wr(8'h00, 32'h13);
      ptm_pulse_src_i.send(8);
      wr(8'h00, 32'h12);
      rc(8'h04, 32'h2, "prescaled count");
      wr(8'h04, 32'h0);
      wr(8'h00, 32'h07);
      ptm_pulse_src_i.send(5);
      wr(8'h00, 32'h06);
      rc(8'h04, 32'h5, "bypass count");
      $display("test external done");
      results();
   end
endmodule // ptm_timer_tb_top
